//--- verilog/hub_port_power_cfg.sv
/*
 * APB register bank: bus-powered port-off mask, power budgets, controller
 * draw, plus mode control and a port status view.
 * Assumes a 32-bit APB master and a synchronous hub core reading outputs.
 */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module hub_port_power_cfg
    import hub_cfg_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hub core view
    output logic [PORTS:1] port_active,
    output logic [7:0] port_count,
    output logic [PORTS*8-1:0] slot_map,
    output logic [7:0] max_power_report,
    output logic [7:0] controller_draw,
    output logic bus_powered,
    output logic port_remap_enable
);

    // ==========================================================
    // registers
    logic [7:0] bus_port_off_mask_r;
    logic [7:0] self_power_budget_r;
    logic [7:0] bus_power_budget_r;
    logic [7:0] self_controller_draw_r;
    logic [1:0] mode_r;
    logic [7:0] port_count_nxt;
    logic [PORTS*8-1:0] slot_map_nxt;
    logic [PORTS:1] active_nxt;

    function automatic logic [7:0] reg_index(input logic [11:0] a);
        return a[9:2];
    endfunction : reg_index

    // identity packing, so slot_map agrees with the all-on port view out of reset
    function automatic logic [PORTS*8-1:0] ident_map();
        logic [PORTS*8-1:0] m;
        m = '0;
        for (int p = 1; p <= PORTS; p++) begin
            m[(p-1)*8 +: 8] = 8'(p);
        end
        return m;
    endfunction : ident_map

    localparam logic [PORTS*8-1:0] SLOT_IDENT = ident_map();

    wire logic access = psel && penable && clk_en;
    wire logic wr_go = access && pwrite && pstrb[0];
    wire logic [7:0] idx = reg_index(paddr);
    wire logic mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
        (idx == IDX_BUS_PORT_OFF || idx == IDX_SELF_BUDGET || idx == IDX_BUS_BUDGET ||
         idx == IDX_SELF_DRAW || idx == IDX_MODE_CTRL || idx == IDX_PORT_STATUS);

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ==========================================================
    // register writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_port_off_mask_r <= RST_BUS_PORT_OFF;
        end else if (wr_go && idx == IDX_BUS_PORT_OFF && mapped) begin
            bus_port_off_mask_r <= pwdata[7:0] & PORT_OFF_WMASK;  // [R1]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            self_power_budget_r <= RST_SELF_BUDGET;
            bus_power_budget_r <= RST_BUS_BUDGET;
            self_controller_draw_r <= RST_SELF_DRAW;
        end else if (wr_go && mapped) begin
            // stored as written: 2 mA units, 2 mA units, 1 mA units
            if (idx == IDX_SELF_BUDGET) begin
                self_power_budget_r <= pwdata[7:0];  // [R5]
            end
            if (idx == IDX_BUS_BUDGET) begin
                bus_power_budget_r <= pwdata[7:0];  // [R6]
            end
            if (idx == IDX_SELF_DRAW) begin
                self_controller_draw_r <= pwdata[7:0];  // [R8]
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= RST_MODE_CTRL;
        end else if (wr_go && idx == IDX_MODE_CTRL && mapped) begin
            mode_r <= pwdata[1:0];
        end
    end

    assign bus_powered = mode_r[MODE_BUS_POWERED_BIT];
    assign port_remap_enable = mode_r[MODE_REMAP_BIT];

    // ==========================================================
    // port packing
    always_comb begin
        active_nxt = '1;
        if (bus_powered && !port_remap_enable) begin  // [R2] [R10]
            active_nxt = ~bus_port_off_mask_r[PORTS:1];
        end
    end

    hub_port_packer #(
        .PORTS(PORTS)
    ) u_packer (
        .port_on(active_nxt),
        .port_count(port_count_nxt),
        .slot_map(slot_map_nxt)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_active <= '1;
            port_count <= 8'(PORTS);
            slot_map <= SLOT_IDENT;
        end else if (clk_en) begin
            port_active <= active_nxt;  // [R2]
            port_count <= port_count_nxt;  // [R3]
            slot_map <= slot_map_nxt;  // [R4]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            max_power_report <= RST_SELF_BUDGET;
            controller_draw <= RST_SELF_DRAW;
        end else if (clk_en) begin
            max_power_report <= bus_powered ? bus_power_budget_r : self_power_budget_r;  // [R11]
            controller_draw <= self_controller_draw_r;
        end
    end

    // ==========================================================
    // read data
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (mapped ? reg_index(paddr) : 8'h00)
                IDX_BUS_PORT_OFF: prdata <= {24'h000000, bus_port_off_mask_r};
                IDX_SELF_BUDGET: prdata <= {24'h000000, self_power_budget_r};
                IDX_BUS_BUDGET: prdata <= {24'h000000, bus_power_budget_r};
                IDX_SELF_DRAW: prdata <= {24'h000000, self_controller_draw_r};
                IDX_MODE_CTRL: prdata <= {30'h00000000, mode_r};
                IDX_PORT_STATUS: prdata <= {16'h0000, port_count, 4'h0, port_active, 1'b0};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // checks
    property p_mask_reserved;
        @(posedge sys_clk) disable iff (!arst_n)
        (bus_port_off_mask_r & ~PORT_OFF_WMASK) == 8'h00;
    endproperty
    a_mask_reserved: assert property (p_mask_reserved) else $error("reserved mask bit set"); // [R1]

    property p_off_in_bus_mode;
        @(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus_powered && !port_remap_enable) |=> (port_active == ~$past(bus_port_off_mask_r[PORTS:1]));
    endproperty
    a_off_in_bus_mode: assert property (p_off_in_bus_mode) else $error("mask not applied"); // [R2]

    property p_all_on_else;
        @(posedge sys_clk) disable iff (!arst_n)
        (clk_en && (!bus_powered || port_remap_enable)) |=> (&port_active);
    endproperty
    a_all_on_else: assert property (p_all_on_else) else $error("port off outside bus mode"); // [R10]

    property p_count;
        @(posedge sys_clk) disable iff (!arst_n)
        port_count == 8'($countones(port_active));
    endproperty
    a_count: assert property (p_count) else $error("port count wrong"); // [R3]

    property p_first_slot;
        @(posedge sys_clk) disable iff (!arst_n)
        (port_count != 8'h00) |-> (port_active[slot_map[7:0]] && slot_map[7:0] != 8'h00);
    endproperty
    a_first_slot: assert property (p_first_slot) else $error("slot 0 not an active port"); // [R4]

    property p_report_bus;
        @(posedge sys_clk) disable iff (!arst_n)
        (clk_en && bus_powered) |=> (max_power_report == $past(bus_power_budget_r));
    endproperty
    a_report_bus: assert property (p_report_bus) else $error("bus budget not reported"); // [R11]

    property p_self_budget_wr;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && mapped && idx == IDX_SELF_BUDGET) |=> (self_power_budget_r == $past(pwdata[7:0]));
    endproperty
    a_self_budget_wr: assert property (p_self_budget_wr) else $error("self budget write lost"); // [R5]

    property p_bus_budget_wr;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && mapped && idx == IDX_BUS_BUDGET) |=> (bus_power_budget_r == $past(pwdata[7:0]));
    endproperty
    a_bus_budget_wr: assert property (p_bus_budget_wr) else $error("bus budget write lost"); // [R6]

    property p_draw_wr;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && mapped && idx == IDX_SELF_DRAW) |=> (self_controller_draw_r == $past(pwdata[7:0]));
    endproperty
    a_draw_wr: assert property (p_draw_wr) else $error("draw write lost"); // [R8]

    property p_draw_follow;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en |=> (controller_draw == $past(self_controller_draw_r));
    endproperty
    a_draw_follow: assert property (p_draw_follow) else $error("draw not forwarded"); // [R8]

    property p_cov_bus_off;
        @(posedge sys_clk) disable iff (!arst_n)
        bus_powered && !port_remap_enable && port_count == 8'h01;
    endproperty
    c_bus_off: cover property (p_cov_bus_off);

    property p_cov_remap;
        @(posedge sys_clk) disable iff (!arst_n)
        port_remap_enable && bus_powered && bus_port_off_mask_r != 8'h00;
    endproperty
    c_remap: cover property (p_cov_remap);

    property p_cov_err;
        @(posedge sys_clk) disable iff (!arst_n)
        pslverr;
    endproperty
    c_err: cover property (p_cov_err);

endmodule : hub_port_power_cfg

//--- inc/hub_cfg_pkg.sv
/*
 * Constants for the hub port-disable and power-figure register bank.
 * Assumes an APB master on a 10 MHz clock; offsets 0x0B..0x0E are not all
 * multiples of four, so each printed offset is an index and the byte
 * address is four times it.
 */
// Functional notes
// R1 - In the bus-powered port-off mask bits 1 to 3 disable ports 1 to 3, and bits 0 and 7:4 are reserved.
// R2 - The bus-powered mask applies only while bus-powered with remap off, and masked ports stay dead.
// R3 - With ports disabled the hub reports only the enabled count and packs active ports contiguously.
// R4 - Any combination of disabled ports is accepted and still yields a working port set; with all three masked the code gives port_count 0.
// R5 - The self-powered budget is in 2 mA units and covers the hub plus board draw on the bus supply.
// R6 - The bus-powered budget is in 2 mA units, so 8 mA is encoded as 4.
// R7 - Software folds a zero-current embedded peripheral's draw into the budgets.
// R8 - The self-powered controller draw is in 1 mA units and excludes the compound peripheral.
// R9 - Software keeps self-powered power and current figures at or below 100 mA.
// R10 - Remap enable at zero uses the mask with contiguous renumbering, at one the remap tables; the code has no remap tables and turns all ports on.
// R11 - The reported maximum power is the budget of the present power mode.
package hub_cfg_pkg;

    // ==========================================================
    // register indices
    localparam logic [7:0] IDX_BUS_PORT_OFF = 8'h0B;
    localparam logic [7:0] IDX_SELF_BUDGET = 8'h0C;
    localparam logic [7:0] IDX_BUS_BUDGET = 8'h0D;
    localparam logic [7:0] IDX_SELF_DRAW = 8'h0E;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h10;
    localparam logic [7:0] IDX_PORT_STATUS = 8'h11;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BUS_PORT_OFF = 8'h00;
    localparam logic [7:0] RST_SELF_BUDGET = 8'h01;
    localparam logic [7:0] RST_BUS_BUDGET = 8'hFA;
    localparam logic [7:0] RST_SELF_DRAW = 8'h02;
    localparam logic [1:0] RST_MODE_CTRL = 2'h0;

    // ==========================================================
    // fields
    localparam logic [7:0] PORT_OFF_WMASK = 8'h0E;
    localparam int MODE_BUS_POWERED_BIT = 0;
    localparam int MODE_REMAP_BIT = 1;
    localparam int NUM_PORTS = 3;

endpackage : hub_cfg_pkg

//--- verilog/hub_port_packer.sv
/*
 * Packs the enabled downstream ports into contiguous logical numbers.
 * Assumes a combinational caller; no state.
 */
`timescale 1ns/1ns
module hub_port_packer #(
    parameter int PORTS = 3
) (
    // physical port enables, index 1..PORTS
    input wire logic [PORTS:1] port_on,
    // count of enabled ports
    output logic [7:0] port_count,
    // logical slot k holds its physical port number, zero if unused
    output logic [PORTS*8-1:0] slot_map
);

    always_comb begin
        logic [7:0] n;
        n = 8'h00;
        slot_map = '0;
        for (int p = 1; p <= PORTS; p++) begin
            if (port_on[p]) begin  // [R3] [R4]
                slot_map[n*8 +: 8] = 8'(p);
                n = n + 8'h01;
            end
        end
        port_count = n;
    end

endmodule : hub_port_packer

//--- verif/hub_host_model.sv
/*
 * Upstream host model: latches what the hub presents at enumeration.
 * Assumes the hub view outputs are settled when enum_req is sampled.
 */
`timescale 1ns/1ns
module hub_host_model (
    // clock
    input wire logic sys_clk,
    // hub view
    input wire logic enum_req,
    input wire logic [7:0] port_count,
    input wire logic [7:0] max_power_report,
    // enumeration result
    output logic [7:0] seen_ports,
    output logic [9:0] seen_ma
);
    // ==========================================================
    // enumeration capture
    always_ff @(posedge sys_clk) begin
        if (enum_req) begin
            seen_ports <= port_count;
            // budget fields count in 2 mA steps
            seen_ma <= {1'b0, max_power_report, 1'b0};
        end
    end
endmodule : hub_host_model

//--- verif/hub_port_power_cfg_test.sv
/*
 * Self-checking bench for the port-disable and power-figure bank.
 * Assumes an APB slave with a registered hub view and a host model.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module hub_port_power_cfg_test;
    import hub_cfg_pkg::*;
    localparam logic [11:0] A_MASK = {2'b00, IDX_BUS_PORT_OFF, 2'b00};
    localparam logic [11:0] A_SELF = {2'b00, IDX_SELF_BUDGET, 2'b00};
    localparam logic [11:0] A_BUS = {2'b00, IDX_BUS_BUDGET, 2'b00};
    localparam logic [11:0] A_DRAW = {2'b00, IDX_SELF_DRAW, 2'b00};
    localparam logic [11:0] A_MODE = {2'b00, IDX_MODE_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_PORT_STATUS, 2'b00};
    logic sys_clk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, enum_req = 0, pready, pslverr, err_q;
    logic bus_powered, port_remap_enable;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [NUM_PORTS:1] port_active;
    logic [7:0] port_count, max_power_report, controller_draw, seen_ports;
    logic [NUM_PORTS*8-1:0] slot_map;
    logic [9:0] seen_ma;
    int errors = 0, n_tests = 0;

    hub_port_power_cfg u_dut (.sys_clk, .arst_n, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .port_active, .port_count, .slot_map, .max_power_report,
        .controller_draw, .bus_powered, .port_remap_enable);
    hub_host_model u_host (.sys_clk, .enum_req, .port_count,
        .max_power_report, .seen_ports, .seen_ma);

    always #50 sys_clk = ~sys_clk;

    // ==========================================================
    // bus and check helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'hFFFFFF, d});
    endtask : wr

    task automatic chk_reg(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, {24'h000000, e})
    endtask : chk_reg

    task automatic check_view(input logic [NUM_PORTS:1] act);
        logic [NUM_PORTS*8-1:0] exp_map;
        int k;
        exp_map = '0;
        k = 0;
        for (int p = 1; p <= NUM_PORTS; p++) begin
            if (act[p]) begin
                exp_map[k*8 +: 8] = 8'(p);
                k++;
            end
        end
        repeat (2) @(posedge sys_clk);
        `CHK(port_active, act)
        `CHK(port_count, 8'(k))
        `CHK(slot_map, exp_map)
        apb(1'b0, A_STAT, 32'h0);
        `CHK(rd, {16'h0000, 8'(k), 4'h0, act, 1'b0})
    endtask : check_view

    task automatic enumerate(input logic [9:0] ma, input logic [7:0] ports);
        @(posedge sys_clk);
        enum_req <= 1'b1;
        @(posedge sys_clk);
        enum_req <= 1'b0;
        @(posedge sys_clk);
        `CHK(seen_ma, ma)
        `CHK(seen_ports, ports)
    endtask : enumerate

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk_reg(A_MASK, RST_BUS_PORT_OFF);
        chk_reg(A_SELF, RST_SELF_BUDGET);
        chk_reg(A_BUS, RST_BUS_BUDGET);
        chk_reg(A_DRAW, RST_SELF_DRAW);
        check_view(3'b111);
        `CHK(max_power_report, RST_SELF_BUDGET)
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask();
        wr(A_MODE, 8'h01);
        for (int m = 0; m < 8; m++) begin
            wr(A_MASK, {4'hF, 3'(m), 1'b1});
            chk_reg(A_MASK, {4'h0, 3'(m), 1'b0});
            check_view(~3'(m));
        end
        $display("test mask done");
    endtask : t_mask

    task automatic t_mode();
        wr(A_MASK, 8'h0A);
        wr(A_MODE, 8'h00);
        check_view(3'b111);
        wr(A_MODE, 8'h03);
        chk_reg(A_MODE, 8'h03);
        check_view(3'b111);
        `CHK(port_remap_enable, 1'b1)
        wr(A_MODE, 8'h01);
        check_view(3'b010);
        $display("test mode done");
    endtask : t_mode

    task automatic t_power();
        wr(A_SELF, 8'h32);
        wr(A_BUS, 8'h04);
        wr(A_DRAW, 8'h08);
        pstrb <= 4'h0;
        wr(A_SELF, 8'h11);
        pstrb <= 4'hF;
        chk_reg(A_SELF, 8'h32);
        chk_reg(A_BUS, 8'h04);
        repeat (2) @(posedge sys_clk);
        `CHK(controller_draw, 8'h08)
        `CHK(max_power_report, 8'h04)
        enumerate(10'd8, 8'h01);
        wr(A_MODE, 8'h00);
        enumerate(10'd100, 8'h03);
        $display("test power done");
    endtask : t_power

    task automatic t_err();
        wr(12'h0C0, 8'h5A);
        `CHK(err_q, 1'b1)
        chk_reg(12'h0C0, 8'h00);
        `CHK(err_q, 1'b1)
        chk_reg(A_MASK, 8'h0A);
        `CHK(err_q, 1'b0)
        $display("test error done");
    endtask : t_err

    task automatic t_freeze();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(A_MODE, 8'h01);
        clk_en <= 1'b1;
        chk_reg(A_MODE, 8'h00);
        check_view(3'b111);
        $display("test freeze done");
    endtask : t_freeze

    // ==========================================================
    // run control
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_mask();
        t_mode();
        t_power();
        t_err();
        t_freeze();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        close_out();
    end
endmodule : hub_port_power_cfg_test
